// [hw/tmls_pkg.sv]
// Constants for the monitoring sequencer, limit checker and register map
package tmls_pkg;
    localparam int NUM_CH = 8;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int CH_W = 3;
    localparam logic [CH_W-1:0] CH_REMOTE = 3'h6;
    localparam logic [CH_W-1:0] CH_LOCAL = 3'h7;
    localparam logic [CH_W-1:0] CH_LAST = 3'h7;
    localparam logic [ADDR_W-1:0] REG_VALUE_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] REG_LOCAL_TEMP = 8'h27;
    localparam logic [ADDR_W-1:0] REG_HIGH_BASE = 8'h2B;
    localparam logic [ADDR_W-1:0] REG_LIMIT_SPAN = 8'h10;
    localparam logic [ADDR_W-1:0] REG_CONFIG = 8'h40;
    localparam logic [ADDR_W-1:0] REG_STATUS_ONE = 8'h41;
    localparam logic [ADDR_W-1:0] REG_STATUS_TWO = 8'h42;
    localparam int CFG_START_BIT = 0;
    localparam int STS2_DIODE_FAULT_BIT = 6;
    localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
    localparam int AVG_COUNT = 16;
    localparam int AVG_SHIFT = 4;
    localparam int AVG_W = 4;
    localparam int SUM_W = 12;
    localparam int CNT_W = 20;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SLOT_TIME_NS = 11_600_000;
    localparam int REMOTE_TIME_NS = 34_800_000;
    localparam int SLOT_CYCLES = SLOT_TIME_NS / CLK_PERIOD_NS;
    localparam int REMOTE_SUB_CYCLES = REMOTE_TIME_NS / (AVG_COUNT * CLK_PERIOD_NS);
    typedef enum logic [1:0] {
        TMLS_IDLE,
        TMLS_CONVERT,
        TMLS_HOLD
    } tmls_state_type;
endpackage : tmls_pkg

// [hw/tmls_monitor.sv]
// Round-robin sequencer, remote averaging, limit checks and register file
//
// How it works
// - Local temperature stored as signed byte
// - Codes span minus 128 to plus 127
// - Remote diode fault sets status two bit
// - Fault input covers shorts and opens
// - Remote result averages sixteen conversions
// - Remote measurement spans nominal 34.8 ms
// - Remote result uses same signed byte
// - Each result stored and checked against limits in the same cycle
// - Status bit rewritten on every measurement
// - Within limits clears the status bit
// - Outside limits sets the status bit
// - Reading status never changes it
// - Writing start bit one begins sequencing
// - Writing start bit zero stops conversions
// - Channels converted in fixed order, stored
// - Status readable while monitoring runs
// - Out-of-limit results raise an event output
// - Other channels use one 11.6 ms slot
// - Reset zeroes registers, converter stays idle
`timescale 1ns/10ps
module tmls_monitor
    import tmls_pkg::*;
#(
    parameter int SLOT_LEN = SLOT_CYCLES,
    parameter int REMOTE_SUB_LEN = REMOTE_SUB_CYCLES
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    output logic adc_start,
    output logic [CH_W-1:0] adc_channel,
    input wire logic adc_done,
    input wire logic [DATA_W-1:0] adc_data,
    input wire logic diode_fault,
    output logic limit_event
);
    localparam logic [CNT_W-1:0] SLOT_LAST = CNT_W'(SLOT_LEN - 1);
    localparam logic [CNT_W-1:0] REMOTE_LAST = CNT_W'(REMOTE_SUB_LEN - 1);

    tmls_state_type state, next_state;
    logic [CH_W-1:0] ch, next_ch;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [AVG_W-1:0] avg_cnt, next_avg_cnt;
    logic [SUM_W-1:0] sum, next_sum;
    logic fault_acc, next_fault_acc;
    logic next_adc_start;
    logic [CH_W-1:0] next_adc_channel;
    logic next_limit_event;
    logic [DATA_W-1:0] value [NUM_CH];
    logic [DATA_W-1:0] next_value [NUM_CH];
    logic [DATA_W-1:0] high [NUM_CH];
    logic [DATA_W-1:0] next_high [NUM_CH];
    logic [DATA_W-1:0] low [NUM_CH];
    logic [DATA_W-1:0] next_low [NUM_CH];
    logic [DATA_W-1:0] status_one, next_status_one;
    logic [DATA_W-1:0] status_two, next_status_two;
    logic [DATA_W-1:0] config_reg, next_config_reg;
    logic [DATA_W-1:0] next_reg_rdata;
    logic [SUM_W-1:0] sum_full;
    logic [DATA_W-1:0] candidate;
    logic [NUM_CH-1:0] out_of_limit;
    logic store;
    logic remote_done;
    logic run;

    assign run = config_reg[CFG_START_BIT];
    // Sign-extended accumulation; the mean is the sum with four bits dropped
    assign sum_full = sum + {{(SUM_W-DATA_W){adc_data[DATA_W-1]}}, adc_data};
    assign remote_done = (avg_cnt == AVG_W'(AVG_COUNT - 1));
    assign candidate = (ch == CH_REMOTE) ? sum_full[AVG_SHIFT +: DATA_W] : adc_data;
    assign store = (state == TMLS_CONVERT) && adc_done && run
        && ((ch != CH_REMOTE) || remote_done);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_cmp
            if (gi == CH_REMOTE || gi == CH_LOCAL) begin : g_signed
                assign out_of_limit[gi] = ($signed(candidate) > $signed(high[gi]))
                    || ($signed(candidate) < $signed(low[gi]));
            end else begin : g_unsigned
                assign out_of_limit[gi] = (candidate > high[gi]) || (candidate < low[gi]);
            end
        end
    endgenerate

    always_comb begin
        next_state = state;
        next_ch = ch;
        next_cnt = cnt + CNT_W'(1);
        next_avg_cnt = avg_cnt;
        next_sum = sum;
        next_fault_acc = fault_acc;
        next_adc_start = 1'b0;
        next_adc_channel = adc_channel;
        next_limit_event = 1'b0;
        next_value = value;
        next_status_one = status_one;
        next_status_two = status_two;
        case (state)
            TMLS_IDLE: begin
                next_cnt = '0;
                if (run) begin
                    next_state = TMLS_CONVERT;
                    next_ch = '0;
                    next_adc_start = 1'b1;
                    next_adc_channel = '0;
                    next_avg_cnt = '0;
                    next_sum = '0;
                    next_fault_acc = 1'b0;
                end
            end
            TMLS_CONVERT: begin
                if (adc_done) begin
                    next_state = TMLS_HOLD;
                    if (ch == CH_REMOTE) begin
                        next_sum = sum_full;
                        next_fault_acc = fault_acc | diode_fault;
                        next_avg_cnt = avg_cnt + AVG_W'(1);
                    end
                    if (store) begin
                        next_value[ch] = candidate;
                        next_status_one[ch] = out_of_limit[ch];
                        next_limit_event = out_of_limit[ch];
                        if (ch == CH_REMOTE) begin
                            next_status_two[STS2_DIODE_FAULT_BIT] = fault_acc | diode_fault;
                            next_sum = '0;
                            next_fault_acc = 1'b0;
                        end
                    end
                end
            end
            TMLS_HOLD: begin
                if (cnt >= ((ch == CH_REMOTE) ? REMOTE_LAST : SLOT_LAST)) begin
                    next_state = TMLS_CONVERT;
                    next_cnt = '0;
                    next_adc_start = 1'b1;
                    if (ch != CH_REMOTE || avg_cnt == '0) begin
                        next_ch = (ch == CH_LAST) ? '0 : ch + CH_W'(1);
                    end
                    next_adc_channel = (ch != CH_REMOTE || avg_cnt == '0)
                        ? ((ch == CH_LAST) ? '0 : ch + CH_W'(1)) : ch;
                end
            end
            default: begin
                next_state = TMLS_IDLE;
            end
        endcase
        if (!run) begin
            next_state = TMLS_IDLE;
            next_adc_start = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= TMLS_IDLE;
            ch <= '0;
            cnt <= '0;
            avg_cnt <= '0;
            sum <= '0;
            fault_acc <= 1'b0;
            adc_start <= 1'b0;
            adc_channel <= '0;
            limit_event <= 1'b0;
            status_one <= RESET_BYTE;
            status_two <= RESET_BYTE;
            for (int i = 0; i < NUM_CH; i++) begin
                value[i] <= RESET_BYTE;
            end
        end else begin
            state <= next_state;
            ch <= next_ch;
            cnt <= next_cnt;
            avg_cnt <= next_avg_cnt;
            sum <= next_sum;
            fault_acc <= next_fault_acc;
            adc_start <= next_adc_start;
            adc_channel <= next_adc_channel;
            limit_event <= next_limit_event;
            status_one <= next_status_one;
            status_two <= next_status_two;
            value <= next_value;
        end
    end

    // Host register access: limits and configuration writable, the rest read-only
    always_comb begin
        logic [ADDR_W-1:0] voff;
        logic [ADDR_W-1:0] loff;
        voff = reg_addr - REG_VALUE_BASE;
        loff = reg_addr - REG_HIGH_BASE;
        next_high = high;
        next_low = low;
        next_config_reg = config_reg;
        next_reg_rdata = reg_rdata;
        if (reg_wr) begin
            if (reg_addr == REG_CONFIG) begin
                next_config_reg = reg_wdata;
            end else if (loff < REG_LIMIT_SPAN) begin
                if (loff[0] == 1'b0) begin
                    next_high[loff[CH_W:1]] = reg_wdata;
                end else begin
                    next_low[loff[CH_W:1]] = reg_wdata;
                end
            end
        end
        if (reg_rd) begin
            next_reg_rdata = RESET_BYTE;
            if (voff < ADDR_W'(NUM_CH)) begin
                next_reg_rdata = value[voff[CH_W-1:0]];
            end else if (loff < REG_LIMIT_SPAN) begin
                next_reg_rdata = loff[0] ? low[loff[CH_W:1]] : high[loff[CH_W:1]];
            end else if (reg_addr == REG_CONFIG) begin
                next_reg_rdata = config_reg;
            end else if (reg_addr == REG_STATUS_ONE) begin
                next_reg_rdata = status_one;
            end else if (reg_addr == REG_STATUS_TWO) begin
                next_reg_rdata = status_two;
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            config_reg <= RESET_BYTE;
            reg_rdata <= RESET_BYTE;
            for (int i = 0; i < NUM_CH; i++) begin
                high[i] <= RESET_BYTE;
                low[i] <= RESET_BYTE;
            end
        end else begin
            config_reg <= next_config_reg;
            reg_rdata <= next_reg_rdata;
            high <= next_high;
            low <= next_low;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    property p_start_begins;
        (state == TMLS_IDLE) && run |=> adc_start && (adc_channel == '0);
    endproperty
    a_start_begins: assert property (p_start_begins) else $error("start did not convert");

    // A restart may follow a stop at once, so only the cycle after a clear start bit is checked
    property p_stop_halts;
        !run |=> !adc_start && (state == TMLS_IDLE);
    endproperty
    a_stop_halts: assert property (p_stop_halts) else $error("conversion after stop");

    property p_status_set;
        store && out_of_limit[ch] |=> status_one[$past(ch)] && limit_event;
    endproperty
    a_status_set: assert property (p_status_set) else $error("out of limit not flagged");

    property p_status_clear;
        store && !out_of_limit[ch] |=> !status_one[$past(ch)] && !limit_event;
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("in limit not cleared");

    property p_local_value;
        store && (ch == CH_LOCAL) |=> value[CH_LOCAL] == $past(adc_data);
    endproperty
    a_local_value: assert property (p_local_value) else $error("local value not stored");

    property p_read_keeps;
        reg_rd && !store |=> status_one == $past(status_one);
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("read changed status");

    property p_read_status;
        reg_rd && (reg_addr == REG_STATUS_TWO) |=> reg_rdata == $past(status_two);
    endproperty
    a_read_status: assert property (p_read_status) else $error("status read wrong");

    property p_diode_fault;
        store && (ch == CH_REMOTE) && diode_fault |=> status_two[STS2_DIODE_FAULT_BIT];
    endproperty
    a_diode_fault: assert property (p_diode_fault) else $error("diode fault not flagged");

    property p_remote_average;
        store && (ch == CH_REMOTE) |-> avg_cnt == AVG_W'(AVG_COUNT - 1);
    endproperty
    a_remote_average: assert property (p_remote_average) else $error("remote stored early");

    property p_slot_gap;
        adc_start |=> !adc_start;
    endproperty
    a_slot_gap: assert property (p_slot_gap) else $error("back to back starts");
endmodule : tmls_monitor

// [dv/tmls_adc_model.sv]
// Behavioural converter answering the sequencer's conversion requests
`timescale 1ns/10ps
module tmls_adc_model
    import tmls_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic adc_start,
    input wire logic slow,
    input wire logic [DATA_W-1:0] sample_data,
    input wire logic sample_fault,
    output logic adc_done,
    output logic [DATA_W-1:0] adc_data,
    output logic diode_fault
);
    int cnt;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 0;
            adc_done <= 1'b0;
            adc_data <= 8'h5A;
            diode_fault <= 1'b0;
        end else begin
            // Outside the done cycle the lines toggle, so the last result shows again every other cycle
            adc_done <= cnt == 1;
            adc_data <= cnt == 1 ? sample_data : ~adc_data;
            diode_fault <= cnt == 1 ? sample_fault : ~diode_fault;
            cnt <= adc_start ? (slow ? 6 : 1) : (cnt > 0 ? cnt - 1 : 0);
        end
    end
endmodule : tmls_adc_model

// [dv/tmls_monitor_bench.sv]
// Self-checking bench for the monitoring sequencer
`timescale 1ns/10ps
module tmls_monitor_bench
    import tmls_pkg::*;
;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic [DATA_W-1:0] sample_data = 8'h00;
    logic [DATA_W-1:0] reg_rdata, adc_data, got;
    logic [CH_W-1:0] adc_channel;
    logic adc_start, adc_done, diode_fault, limit_event;
    logic slow = 1'b0;
    logic sample_fault = 1'b0;
    logic rnd_mode = 1'b0;
    logic armed = 1'b0;
    logic flt = 1'b0;
    logic [31:0] lfsr = 32'hC5542BAD;
    logic [7:0] hi [8], lo [8], val [8], dir_data [8];
    logic [7:0] sts1 = 8'h00;
    logic [7:0] sts2 = 8'h00;
    int mismatches = 0;
    int tests_run = 0;
    int acc = 0, n6 = 0, avg = 0, pos = 0, rounds = 0, ev_exp = 0, ev_seen = 0;

    always #25 core_clk = ~core_clk;

    tmls_monitor #(.SLOT_LEN(20), .REMOTE_SUB_LEN(10)) i_dut (.core_clk(core_clk),
        .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_start(adc_start),
        .adc_channel(adc_channel), .adc_done(adc_done), .adc_data(adc_data),
        .diode_fault(diode_fault), .limit_event(limit_event));
    tmls_adc_model i_adc (.core_clk(core_clk), .arst_n(arst_n), .adc_start(adc_start),
        .slow(slow), .sample_data(sample_data), .sample_fault(sample_fault),
        .adc_done(adc_done), .adc_data(adc_data), .diode_fault(diode_fault));

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check8

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        @(negedge core_clk);
        got = reg_rdata;
    endtask : rd

    // Reference of one stored result and its limit comparison
    task automatic store(input int c, input logic [7:0] v);
        logic o;
        val[c] = v;
        o = (c >= 6) ? ($signed(v) > $signed(hi[c]) || $signed(v) < $signed(lo[c]))
                     : (v > hi[c] || v < lo[c]);
        sts1[c] = o;
        ev_exp += o;
    endtask : store

    always @(negedge core_clk) begin
        lfsr = lfsr_next(lfsr);
        sample_data <= rnd_mode ? lfsr[7:0] : dir_data[adc_channel];
        sample_fault <= rnd_mode && lfsr[11:8] == 4'h0;
        slow <= lfsr[12];
        if (limit_event === 1'b1) ev_seen++;
        if (adc_start === 1'b1) begin
            check8("armed", 8'h01, {7'h00, armed});
            check8("channel", pos < 6 ? 8'(pos) : (pos < 22 ? 8'h06 : 8'h07),
                {5'h00, adc_channel});
            pos = (pos + 1) % 23;
        end
        if (adc_done === 1'b1 && adc_channel == CH_REMOTE) begin
            acc += int'($signed(adc_data));
            flt |= diode_fault;
            n6++;
            if (n6 == AVG_COUNT) begin
                avg = acc >>> AVG_SHIFT;
                store(6, avg[7:0]);
                sts2 = {1'b0, flt, 6'h00};
                acc = 0;
                n6 = 0;
                flt = 1'b0;
            end
        end else if (adc_done === 1'b1) begin
            store(int'(adc_channel), adc_data);
            if (adc_channel == CH_LAST) rounds++;
        end
    end

    task automatic run_round();
        for (int c = 0; c < 8; c++) begin
            wr(REG_HIGH_BASE + 8'(2 * c), hi[c]);
            wr(REG_HIGH_BASE + 8'(2 * c + 1), lo[c]);
        end
        rounds = 0;
        pos = 0;
        armed = 1'b1;
        wr(REG_CONFIG, 8'h01);
        rd(REG_CONFIG);
        check8("config", 8'h01, got);
        for (int i = 0; i < 3000 && rounds == 0; i++) @(negedge core_clk);
        if (rounds == 0) begin
            mismatches++;
            $display("mismatch round expected 1 seen 0");
            print_verdict();
        end
        armed = 1'b0;
        wr(REG_CONFIG, 8'h00);
        wr(REG_LOCAL_TEMP, 8'hA5);
        repeat (60) @(negedge core_clk);
        check8("events", 8'(ev_exp), 8'(ev_seen));
        for (int c = 0; c < 8; c++) begin
            rd(REG_VALUE_BASE + 8'(c));
            check8("value", val[c], got);
        end
        rd(REG_STATUS_ONE);
        check8("status one", sts1, got);
        rd(REG_STATUS_ONE);
        check8("status one again", sts1, got);
        rd(REG_STATUS_TWO);
        check8("status two", sts2, got);
    endtask : run_round

    initial begin
        repeat (12) @(negedge core_clk);
        arst_n = 1'b1;
        for (int a = 8'h20; a < 8'h43; a++) begin
            rd(8'(a));
            check8("after reset", RESET_BYTE, got);
        end
        for (int c = 0; c < 6; c++) begin
            dir_data[c] = 8'h3C + 8'(c);
            lo[c] = dir_data[c] + 8'(c == 1);
            hi[c] = dir_data[c] - 8'(c == 3);
        end
        dir_data[6] = 8'hFF;
        lo[6] = 8'hF0;
        hi[6] = 8'h05;
        dir_data[7] = 8'h80;
        lo[7] = 8'h80;
        hi[7] = 8'h7F;
        run_round();
        rnd_mode = 1'b1;
        for (int c = 0; c < 8; c++) begin
            lfsr = lfsr_next(lfsr);
            lo[c] = lfsr[7:0];
            hi[c] = lfsr[15:8];
        end
        run_round();
        // Reset while the sequencer runs: everything back to zero, no restart
        pos = 0;
        wr(REG_CONFIG, 8'h01);
        armed = 1'b1;
        repeat (30) @(negedge core_clk);
        arst_n = 1'b0;
        @(negedge core_clk);
        armed = 1'b0;
        @(negedge core_clk);
        arst_n = 1'b1;
        repeat (40) @(negedge core_clk);
        rd(REG_CONFIG);
        check8("config after reset", RESET_BYTE, got);
        rd(REG_VALUE_BASE);
        check8("value after reset", RESET_BYTE, got);
        rd(REG_HIGH_BASE);
        check8("limit after reset", RESET_BYTE, got);
        rd(REG_STATUS_ONE);
        check8("status after reset", RESET_BYTE, got);
        print_verdict();
    end
endmodule : tmls_monitor_bench
